// ==== rsm_reset_source_manager.sv ====
/*
 * Reset source manager: gathers the internal reset sources, drives the
 * system reset, records the cause of the last reset and exposes one
 * byte register over classic Wishbone.
 * Assumes rstn_i is the power-on reset, which this block survives no
 * other way; a system reset it issues clears the detector, comparator and usb enables and turns the watchdog back on.
 * mcd_osc_clk_i is a free-running low-frequency oscillator that does not
 * depend on sys_clk_i.
 */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defines.svh"

module rsm_reset_source_manager #(
    parameter int unsigned MCD_TIMEOUT_TICKS = `RSM_MCD_TIMEOUT_TICKS
) (
    input  wire logic        sys_clk_i,       // system clock, 10 MHz
    input  wire logic        rstn_i,          // power-on reset, active low
    input  wire logic        mcd_osc_clk_i,   // detector's own oscillator
    input  wire logic        wb_cyc_i,        // wishbone cycle
    input  wire logic        wb_stb_i,        // wishbone strobe
    input  wire logic        wb_we_i,         // wishbone write enable
    input  wire logic [9:0]  wb_adr_i,        // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,        // wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,        // wishbone write data
    output logic      [31:0] wb_dat_o,        // wishbone read data
    output logic             wb_ack_o,        // wishbone acknowledge
    input  wire logic        ext_rst_n_i,     // external reset pin level
    input  wire logic        vdd_below_i,     // supply monitor: below limit
    input  wire logic        cmp_out_i,       // comparator: plus above minus
    input  wire logic        wdt_overflow_i,  // watchdog overflow pulse
    input  wire logic        wdt_disable_i,   // watchdog disable pulse
    input  wire logic        code_access_i,   // code memory access strobe
    input  wire logic [15:0] code_addr_i,     // code memory access address
    input  wire logic        usb_bus_reset_i, // usb reset signaling seen
    input  wire logic        usb_ctrl_en_i,   // usb controller enabled
    input  wire logic        vbus_i,          // bus power pin level
    input  wire logic        bus_power_edge_polarity_i, // 1 rising edge
    output logic             sys_rst_n_o,     // system reset, active low
    output logic             mcd_reset_n_o,   // detector reset, active low
    output logic             wdt_enable_o,    // watchdog enabled
    output logic             wdt_tick_o       // watchdog tick, clock / 12
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int SYNC_W = 5;
    localparam int S_PIN  = 0;
    localparam int S_VDD  = 1;
    localparam int S_CMP  = 2;
    localparam int S_VBUS = 3;
    localparam int S_MCD  = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = `RSM_SYNC_RST;

    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              vbus_prev;

    rsm_pkg::rsm_state_t state;
    rsm_pkg::rsm_state_t next_state;
    rsm_pkg::rsm_flags_t cause;
    rsm_pkg::rsm_flags_t next_cause;
    rsm_pkg::rsm_flags_t req;
    logic [3:0]          rst_cnt;
    logic [3:0]          next_rst_cnt;
    logic                hold;
    logic                start;

    logic       mcd_en;
    logic       cmp_en;
    logic       usb_en;
    logic       vdd_en;

    logic       bus_acc;
    logic       bus_hit;
    logic       bus_wr;
    logic       vbus_edge;
    logic       mem_err;

    logic [3:0] wdt_div;

    logic       heartbeat;
    logic [2:0] hb_sync;
    logic [1:0] en_sync;
    logic [15:0] mcd_cnt;

    ////////////////////////////////////////////////////////////////////////
    // priority of simultaneous causes: the pin first, software last

    function automatic rsm_pkg::rsm_flags_t first_cause(
        input rsm_pkg::rsm_flags_t r
    );
        rsm_pkg::rsm_flags_t f;
        f = 8'h00;
        if (r[`RSM_BIT_PIN]) begin
            f[`RSM_BIT_PIN] = 1'b1;
        end else if (r[`RSM_BIT_POR]) begin
            f[`RSM_BIT_POR] = 1'b1;
        end else if (r[`RSM_BIT_MCD]) begin
            f[`RSM_BIT_MCD] = 1'b1;
        end else if (r[`RSM_BIT_MEM]) begin
            f[`RSM_BIT_MEM] = 1'b1;
        end else if (r[`RSM_BIT_WDT]) begin
            f[`RSM_BIT_WDT] = 1'b1;
        end else if (r[`RSM_BIT_CMP]) begin
            f[`RSM_BIT_CMP] = 1'b1;
        end else if (r[`RSM_BIT_USB]) begin
            f[`RSM_BIT_USB] = 1'b1;
        end else if (r[`RSM_BIT_SW]) begin
            f[`RSM_BIT_SW] = 1'b1;
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // missing clock detector, on its own oscillator so that a stalled
    // system clock cannot stall the detector as well

    // heartbeat toggles on every rising system clock edge and retriggers the
    // one-shot; a stuck clock freezes it high or low
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            heartbeat <= 1'b0;
        end else begin
            heartbeat <= ~heartbeat;
        end
    end

    always_ff @(posedge mcd_osc_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hb_sync <= 3'h0;
            en_sync <= 2'h0;
        end else begin
            hb_sync <= {hb_sync[1:0], heartbeat};
            en_sync <= {en_sync[0], mcd_en};
        end
    end

    // the oscillator must run well below the system clock, otherwise a
    // healthy heartbeat looks frozen between two toggles
    always_ff @(posedge mcd_osc_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mcd_cnt       <= 16'h0000;
            mcd_reset_n_o <= 1'b1;
        end else if (!en_sync[1] || hb_sync[2] != hb_sync[1]) begin
            mcd_cnt       <= 16'h0000;
            mcd_reset_n_o <= 1'b1;
        end else if (32'(mcd_cnt) >= MCD_TIMEOUT_TICKS) begin
            mcd_reset_n_o <= 1'b0;
        end else begin
            mcd_cnt <= mcd_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for the levels from outside the clock domain

    assign async_in = {mcd_reset_n_o, vbus_i, cmp_out_i, vdd_below_i,
                       ext_rst_n_i};

    generate
        for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sync1[i] <= SYNC_RST[i];
                    sync2[i] <= SYNC_RST[i];
                end else begin
                    sync1[i] <= async_in[i];
                    sync2[i] <= sync1[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vbus_prev <= 1'b0;
        end else begin
            vbus_prev <= sync2[S_VBUS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset requests

    assign vbus_edge = (sync2[S_VBUS] != vbus_prev) &&
                       (sync2[S_VBUS] == bus_power_edge_polarity_i);

    assign mem_err = code_access_i &&
                     (code_addr_i > `RSM_USER_CODE_LIMIT);

    // level sources other than the comparator, whose enable the reset clears, keep the system in reset for as long as they last
    assign hold = !sync2[S_PIN] || (vdd_en && sync2[S_VDD]) ||
                  (cmp_en && !sync2[S_CMP]) || !sync2[S_MCD];

    always_comb begin
        req = 8'h00;
        req[`RSM_BIT_PIN] = !sync2[S_PIN];
        req[`RSM_BIT_POR] = vdd_en && sync2[S_VDD];
        req[`RSM_BIT_MCD] = !sync2[S_MCD];
        req[`RSM_BIT_WDT] = wdt_overflow_i;
        req[`RSM_BIT_CMP] = cmp_en && !sync2[S_CMP];
        req[`RSM_BIT_MEM] = mem_err;
        req[`RSM_BIT_SW]  = bus_wr && wb_dat_i[`RSM_BIT_SW];
        req[`RSM_BIT_USB] = usb_en && ((usb_bus_reset_i && usb_ctrl_en_i)
                            || vbus_edge);
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer; requests that arrive while a reset runs are lost,
    // as the core is held and no cause can be told apart anyway

    always_comb begin
        next_state   = state;
        next_cause   = cause;
        next_rst_cnt = rst_cnt;
        start        = 1'b0;
        unique case (state)
            rsm_pkg::RSM_RUN: begin
                if (req != 8'h00) begin
                    start        = 1'b1;
                    next_state   = rsm_pkg::RSM_RESET;
                    // one flag only, so the power-on flag drops too
                    next_cause   = first_cause(req);
                    next_rst_cnt = 4'(`RSM_RST_PULSE_CYC);
                end
            end
            rsm_pkg::RSM_RESET: begin
                if (rst_cnt != 4'h0) begin
                    next_rst_cnt = rst_cnt - 4'h1;
                end else if (!hold) begin
                    next_state = rsm_pkg::RSM_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state   <= rsm_pkg::RSM_RESET;
            rst_cnt <= 4'(`RSM_RST_PULSE_CYC);
        end else begin
            state   <= next_state;
            rst_cnt <= next_rst_cnt;
        end
    end

    // cause flags: power-on leaves only the power-on flag
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cause <= `RSM_FLAGS_POR;
        end else begin
            cause <= next_cause;
        end
    end

    // only the core sees this reset; the external pin is never driven
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_rst_n_o <= 1'b0;
        end else begin
            sys_rst_n_o <= (next_state == rsm_pkg::RSM_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source enables; they read back as the cause flags, not as written

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mcd_en <= 1'b0;
            cmp_en <= 1'b0;
            usb_en <= 1'b0;
            vdd_en <= `RSM_VDD_EN_POR;
        end else if (start) begin
            mcd_en <= 1'b0;
            cmp_en <= 1'b0;
            usb_en <= 1'b0;
        end else if (bus_wr) begin
            mcd_en <= wb_dat_i[`RSM_BIT_MCD];
            cmp_en <= wb_dat_i[`RSM_BIT_CMP];
            usb_en <= wb_dat_i[`RSM_BIT_USB];
            vdd_en <= wb_dat_i[`RSM_BIT_POR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter-array watchdog enable and its tick

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdt_enable_o <= 1'b1;
        end else if (start) begin
            wdt_enable_o <= 1'b1;
        end else if (wdt_disable_i) begin
            wdt_enable_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdt_div    <= 4'h0;
            wdt_tick_o <= 1'b0;
        end else if (start || wdt_div == 4'(`RSM_WDT_DIV - 1)) begin
            wdt_div    <= 4'h0;
            wdt_tick_o <= !start;
        end else begin
            wdt_div    <= wdt_div + 4'h1;
            wdt_tick_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, unmapped reads return zero and
    // unmapped writes are dropped

    assign bus_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_hit = (wb_adr_i == `RSM_REG_ADDR);
    // a write lands at the edge that sees ack high, as the master expects
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && bus_hit &&
                     wb_we_i && wb_sel_i[0];

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_acc;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_acc && bus_hit && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, cause};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// ==== rsm_defines.svh ====
/*
 * Constants of the reset source manager: register placement, field
 * positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a Wishbone bus with 32-bit data.
 */
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH

// register index and its byte address on the bus
`define RSM_REG_INDEX      8'hEF
`define RSM_REG_ADDR       ({`RSM_REG_INDEX, 2'b00})

// field positions of reset_cause_and_enable
`define RSM_BIT_PIN        0
`define RSM_BIT_POR        1
`define RSM_BIT_MCD        2
`define RSM_BIT_WDT        3
`define RSM_BIT_SW         4
`define RSM_BIT_CMP        5
`define RSM_BIT_MEM        6
`define RSM_BIT_USB        7

// reset values
`define RSM_FLAGS_POR      8'h02
`define RSM_VDD_EN_POR     1'b0
`define RSM_SYNC_RST       5'h15

// code space limit of user code
`define RSM_USER_CODE_LIMIT 16'h3FFF

// timing
`define RSM_CLK_HZ         10000000
`define RSM_RST_PULSE_NS   1000
`define RSM_RST_PULSE_CYC  ((`RSM_RST_PULSE_NS * (`RSM_CLK_HZ / 1000000) + 999) / 1000)
`define RSM_WDT_DIV        12
`define RSM_MCD_TIMEOUT_TICKS 4

`endif

// ==== rsm_pkg.sv ====
/*
 * Types of the reset source manager.
 * Assumes rsm_defines.svh supplies the numeric constants.
 */
package rsm_pkg;

    typedef logic [7:0] rsm_flags_t;

    typedef enum logic {
        RSM_RUN,
        RSM_RESET
    } rsm_state_t;

endpackage

// ==== rsm_sva.sv ====
/* Port assertions of the reset source manager.
   Assumes one clock domain and bind by port name. */
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defines.svh"
module rsm_sva #(
    parameter int unsigned MCD_TIMEOUT_TICKS = 4
) (
    input wire logic        sys_clk_i,      // clock
    input wire logic        rstn_i,         // power-on reset
    input wire logic        wb_cyc_i,       // cycle
    input wire logic        wb_stb_i,       // strobe
    input wire logic        wb_we_i,        // write
    input wire logic [9:0]  wb_adr_i,       // address
    input wire logic [3:0]  wb_sel_i,       // lanes
    input wire logic [31:0] wb_dat_i,       // write data
    input wire logic        wb_ack_o,       // ack
    input wire logic        cmp_out_i,      // comparator
    input wire logic        wdt_overflow_i, // overflow
    input wire logic        code_access_i,  // code access
    input wire logic [15:0] code_addr_i,    // code address
    input wire logic        sys_rst_n_o,    // system reset
    input wire logic        wdt_enable_o,   // watchdog on
    input wire logic        wdt_tick_o      // watchdog tick
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic reg_wr;
    logic cmp_en;
    assign reg_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                    && wb_adr_i == `RSM_REG_ADDR && wb_sel_i[0];
    // mirror of the comparator enable; a system reset drops it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp_en <= 1'b0;
        end else if (!sys_rst_n_o) begin
            cmp_en <= 1'b0;
        end else if (reg_wr) begin
            cmp_en <= wb_dat_i[5];
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence sw_req;
        reg_wr && wb_dat_i[4] && sys_rst_n_o;
    endsequence
    sequence long_low;
        (!sys_rst_n_o) [*8];
    endsequence
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    wdt_reset_a: assert property (
        wdt_overflow_i && sys_rst_n_o |-> ##[1:2] !sys_rst_n_o)
        else $error("overflow gave no reset");
    mem_reset_a: assert property (
        code_access_i && code_addr_i > 16'h3FFF && sys_rst_n_o
        |-> ##[1:2] !sys_rst_n_o) else $error("no memory error reset");
    sw_reset_a: assert property (sw_req |-> ##[1:3] !sys_rst_n_o)
        else $error("forced reset missing");
    cmp_reset_a: assert property (
        cmp_en && !cmp_out_i && sys_rst_n_o |-> ##[1:5] !sys_rst_n_o)
        else $error("comparator reset missing");
    wdt_on_a: assert property ($rose(sys_rst_n_o) |-> wdt_enable_o)
        else $error("watchdog off after reset");
    tick_gap_a: assert property (wdt_tick_o && sys_rst_n_o |=>
        (!wdt_tick_o || !sys_rst_n_o) [*8]) else $error("tick too early");
    low_hold_a: assert property ($fell(sys_rst_n_o) |-> long_low)
        else $error("system reset too short");
endmodule
bind rsm_reset_source_manager rsm_sva #(
    .MCD_TIMEOUT_TICKS(MCD_TIMEOUT_TICKS)
) u_sva (.*);
`default_nettype wire

// ==== rsm_src_model.sv ====
/* Model of the reset sources around the block: pin, supply monitor,
   comparator, bus power pin and the detector's own oscillator.
   Assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module rsm_src_model (
    input  wire logic sys_clk_i,   // system clock
    input  wire logic sys_rst_n_i, // system reset from the block
    output logic      osc_clk_o,   // detector oscillator
    output logic      ext_rst_n_o, // reset pin level
    output logic      vdd_below_o, // supply below limit
    output logic      cmp_out_o,   // 1 while plus above minus
    output logic      vbus_o       // bus power pin
);
    logic [2:0] act = 3'h0;
    logic       vbus_q = 1'b0;
    assign ext_rst_n_o = !act[0];
    assign vdd_below_o = act[1];
    assign cmp_out_o   = !act[2]; // (settled high from start)
    assign vbus_o      = vbus_q;
    // free-running and slow, never derived from the system clock
    initial begin
        osc_clk_o = 1'b0;
        forever #400 osc_clk_o = ~osc_clk_o;
    end
    // hold a level source until the block answers, then let go
    task automatic dip(input int which);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        act[which] <= 1'b1;
        while (sys_rst_n_i && n < 50) begin
            @(posedge sys_clk_i);
            n++;
        end
        repeat (4) @(posedge sys_clk_i);
        act[which] <= 1'b0;
    endtask
    task automatic set_vbus(input logic lvl);
        @(posedge sys_clk_i);
        vbus_q <= lvl;
    endtask
endmodule
`default_nettype wire

// ==== rsm_testbench.sv ====
/* Self-checking bench of the reset source manager.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "rsm_defines.svh"
module testbench;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, clk_run = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic mcd_osc_clk_i, ext_rst_n_i, vdd_below_i, cmp_out_i, vbus_i;
    logic wdt_overflow_i = 1'b0, wdt_disable_i = 1'b0;
    logic code_access_i = 1'b0, usb_bus_reset_i = 1'b0;
    logic usb_ctrl_en_i = 1'b0, bus_power_edge_polarity_i = 1'b1;
    logic [15:0] code_addr_i = 16'h0000;
    logic sys_rst_n_o, mcd_reset_n_o, wdt_enable_o, wdt_tick_o;
    logic [7:0] junk;
    int fail_count = 0, tests_run = 0;
    rsm_reset_source_manager #(.MCD_TIMEOUT_TICKS(4)) u_dut (.*);
    rsm_src_model u_src (
        .sys_clk_i(sys_clk_i), .sys_rst_n_i(sys_rst_n_o),
        .osc_clk_o(mcd_osc_clk_i), .ext_rst_n_o(ext_rst_n_i),
        .vdd_below_o(vdd_below_i), .cmp_out_o(cmp_out_i), .vbus_o(vbus_i)
    );
    initial forever #50 if (clk_run) sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // whole-byte writes only; read values are flags, not enables
    task automatic bus(input logic we, input logic [9:0] a,
        input logic [3:0] s, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i}
            <= {2'b11, we, a, s, 24'h0, d};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        check("bus ack", 8'h01, {7'h0, wb_ack_o});
    endtask
    task automatic wait_rst(input logic lvl, input string what);
        int n;
        n = 0;
        while (sys_rst_n_o !== lvl && n < 300) begin
            @(posedge sys_clk_i);
            n++;
        end
        check(what, {7'h0, lvl}, {7'h0, sys_rst_n_o});
    endtask
    task automatic expect_reset(input logic [7:0] exp);
        wait_rst(1'b0, "reset entered");
        wait_rst(1'b1, "reset left");
        bus(1'b0, `RSM_REG_ADDR, 4'h1, 8'h00, junk);
        check("cause flags", exp, junk);
        check("watchdog on", 8'h01, {7'h0, wdt_enable_o});
    endtask
    task automatic quiet(input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge sys_clk_i);
            ok = ok & sys_rst_n_o;
        end
        check("no reset", 8'h01, {7'h0, ok});
    endtask
    task automatic wr(input logic [7:0] d);
        bus(1'b1, `RSM_REG_ADDR, 4'h1, d, junk);
    endtask
    task automatic fetch(input logic [15:0] a);
        @(posedge sys_clk_i);
        {code_access_i, code_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i);
        code_access_i <= 1'b0;
    endtask
    task automatic stall();
        repeat (4) @(posedge sys_clk_i);
        clk_run = 1'b0;
        #10000;
        clk_run = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        int n;
        bus(1'b0, `RSM_REG_ADDR, 4'h1, 8'h00, junk);
        check("after power-on", 8'h02, junk);
        bus(1'b0, 10'h000, 4'h1, 8'h00, junk);
        check("unmapped read", 8'h00, junk);
        wait_rst(1'b1, "power-on release");
        wr(8'h00);
        bus(1'b1, `RSM_REG_ADDR, 4'h0, 8'h10, junk);
        quiet(30);
        for (n = 0; n < 40 && wdt_tick_o !== 1'b1; n++) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        for (n = 1; n < 40 && wdt_tick_o !== 1'b1; n++) @(posedge sys_clk_i);
        check("tick spacing", 8'h0C, n[7:0]);
    endtask
    task automatic t_watchdog();
        @(posedge sys_clk_i);
        wdt_overflow_i <= 1'b1;
        @(posedge sys_clk_i);
        wdt_overflow_i <= 1'b0;
        expect_reset(8'h08);
        wdt_disable_i <= 1'b1;
        @(posedge sys_clk_i);
        wdt_disable_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        check("watchdog off", 8'h00, {7'h0, wdt_enable_o});
    endtask
    task automatic t_usb();
        wr(8'h80);
        usb_bus_reset_i <= 1'b1;
        @(posedge sys_clk_i);
        usb_bus_reset_i <= 1'b0;
        quiet(20);
        {usb_ctrl_en_i, usb_bus_reset_i} <= 2'b11;
        @(posedge sys_clk_i);
        {usb_ctrl_en_i, usb_bus_reset_i} <= 2'b00;
        expect_reset(8'h80);
        wr(8'h80);
        bus_power_edge_polarity_i <= 1'b0;
        u_src.set_vbus(1'b1);
        quiet(20);
        u_src.set_vbus(1'b0);
        expect_reset(8'h80);
        wr(8'h80);
        bus_power_edge_polarity_i <= 1'b1;
        u_src.set_vbus(1'b1);
        expect_reset(8'h80);
    endtask
    task automatic t_mcd();
        stall();
        quiet(40);
        wr(8'h04);
        stall();
        expect_reset(8'h04);
        repeat (60) @(posedge sys_clk_i);
        check("detector released", 8'h01, {7'h0, mcd_reset_n_o});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_power_on();
        wr(8'h10);
        expect_reset(8'h10);
        t_watchdog();
        fetch(16'h3FFF);
        quiet(20);
        fetch(16'h4000);
        expect_reset(8'h40);
        wr(8'h20);
        quiet(20);
        fork
            u_src.dip(2);
            expect_reset(8'h20);
        join
        t_usb();
        t_mcd();
        fork
            u_src.dip(0);
            expect_reset(8'h01);
        join
        wr(8'h02); // (supply already stable)
        quiet(10);
        fork
            u_src.dip(1);
            expect_reset(8'h02);
        join
        conclude();
    end
endmodule
`default_nettype wire
